// file: ssp_card.sv
/*
 Card model for the socket presence bench: drives the four card pins.
 Assumes the bench sets presence and pin levels just after clock edges.
*/
`timescale 1ns/100ps
module ssp_card
(
   // Bench controls.
   input  wire logic present,
   input  wire logic sts_lvl,
   input  wire logic rdy_lvl,
   // Card pins.
   output logic      det_a,
   output logic      det_b,
   output logic      sts_pin,
   output logic      rdy_pin
);
   // Detect lines have pull-ups; status and ready lines have pull-downs.
   assign det_a   = ~present;
   assign det_b   = ~present;
   assign sts_pin = present & sts_lvl;
   assign rdy_pin = present & rdy_lvl;
endmodule // ssp_card

// file: ssp_pkg.sv
/*
 Constants for the socket presence status block: register offsets,
 field positions and values after reset.
 Assumes a 12-bit APB byte address within the socket register space.
*/
package ssp_pkg;
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] OFF_EVENT     = 12'h000;
   localparam logic [11:0] OFF_MASK      = 12'h004;
   localparam logic [11:0] OFF_PRESENT   = 12'h008;
   localparam logic [11:0] OFF_FORCE     = 12'h00C;
   localparam logic [11:0] OFF_CTRL      = 12'h010;
   localparam int          B_LOWEST_VCC  = 31;
   localparam int          B_LOW_VCC     = 30;
   localparam int          B_THREE_VOLT  = 29;
   localparam int          B_FIVE_VOLT   = 28;
   localparam int          B_RSVD_HI     = 27;
   localparam int          B_RSVD_LO     = 14;
   localparam int          B_VS_TEST     = 14;
   localparam int          B_CARD_HI     = 13;
   localparam int          B_CARD_LO     = 10;
   localparam int          B_BAD_REQ     = 9;
   localparam int          B_LOSS        = 8;
   localparam int          B_UNREC       = 7;
   localparam int          B_READY_PIN   = 6;
   localparam int          B_WIDE_CARD   = 5;
   localparam int          B_NARROW_CARD = 4;
   localparam int          B_POWERED     = 3;
   localparam int          B_DET_B       = 2;
   localparam int          B_DET_A       = 1;
   localparam int          B_STS_PIN     = 0;
   localparam int          B_FIVE_OFF    = 6;
   localparam int          EV_W          = 4;
   localparam logic        RST_THREE_CAP = 1'b1;
   localparam logic [3:0]  RST_EVENT     = 4'h0;
   localparam logic [3:0]  RST_MASK      = 4'h0;
   localparam logic [3:0]  RST_CARD_VCC  = 4'h0;
   localparam logic [1:0]  RST_DETECT    = 2'h3;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
endpackage

// file: ssp_top.sv
/*
 Socket presence status register bank with event, mask, force and
 control registers behind an APB slave, and one level interrupt.
 Assumes the card pins are asynchronous, while the interrogation,
 power and error inputs come from logic on CLK.
*/
`timescale 1ns/100ps
module ssp_top
(
   // Clock and reset.
   input  wire logic                       CLK,
   input  wire logic                       RST_B,
   // APB slave.
   input  wire logic                       PSEL,
   input  wire logic                       PENABLE,
   input  wire logic                       PWRITE,
   input  wire logic [ssp_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]                PWDATA,
   output logic      [31:0]                PRDATA,
   output logic                            PREADY,
   output logic                            PSLVERR,
   // Card socket pins.
   input  wire logic                       DETECT_PIN_A,
   input  wire logic                       DETECT_PIN_B,
   input  wire logic                       CARD_STATUS_CHANGE_PIN,
   input  wire logic                       CARD_READY_INTERRUPT_PIN,
   // Interrogation and power logic.
   input  wire logic                       IDENT_ACTIVE,
   input  wire logic                       INSERT_DONE,
   input  wire logic [3:0]                 CARD_VCC,
   input  wire logic                       CARD_WIDE,
   input  wire logic                       CARD_NARROW,
   input  wire logic                       CARD_INVALID,
   input  wire logic                       BAD_SUPPLY_REQ,
   input  wire logic                       LOSS_EVENT,
   input  wire logic                       SOCKET_POWERED,
   // Outputs to the system.
   output logic                            REINTERROGATE,
   output logic                            IRQ
);
   import ssp_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   logic [3:0]  meta_q;
   logic [3:0]  sync_q;
   logic        sts_prev_q;
   logic [1:0]  det_q;
   logic [1:0]  det_d;
   logic        pwr_q;
   logic        pwr_d;
   logic [3:0]  card_vcc_q;
   logic [3:0]  card_vcc_d;
   logic        wide_q;
   logic        wide_d;
   logic        narrow_q;
   logic        narrow_d;
   logic        unrec_q;
   logic        unrec_d;
   logic        bad_q;
   logic        bad_d;
   logic        loss_q;
   logic        loss_d;
   logic        three_q;
   logic        three_d;
   logic        five_off_q;
   logic        five_off_d;
   logic [3:0]  ev_q;
   logic [3:0]  ev_d;
   logic [3:0]  ev_set;
   logic [3:0]  mask_q;
   logic [3:0]  mask_d;
   logic        pready_q;
   logic        pready_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        pslverr_q;
   logic        pslverr_d;
   logic        reint_q;
   logic        reint_d;
   logic        irq_q;
   logic        irq_d;
   logic        done;
   logic        wr_force;
   logic [31:0] pres;
   logic        mapped;

   // Two-flop synchronisers for the pins: {ready, status, B, A}.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      // Detect lines idle high, so they leave reset high and no false removal event follows.
      if (!RST_B)
      begin
         meta_q <= {2'b00, RST_DETECT};
         sync_q <= {2'b00, RST_DETECT};
      end
      else
      begin
         meta_q <= {CARD_READY_INTERRUPT_PIN, CARD_STATUS_CHANGE_PIN, DETECT_PIN_B, DETECT_PIN_A};
         sync_q <= meta_q;
      end
   end

   assign done     = PSEL & PENABLE & pready_q;
   assign wr_force = done & PWRITE & hit(PADDR, OFF_FORCE);
   assign mapped   = hit(PADDR, OFF_EVENT) | hit(PADDR, OFF_MASK) | hit(PADDR, OFF_PRESENT)
                   | hit(PADDR, OFF_FORCE) | hit(PADDR, OFF_CTRL);

   // The presence word; live pin levels come straight from the synchronisers.
   always_comb
   begin
      pres                                = RST_WORD;
      pres[B_LOWEST_VCC]                  = 1'b0;
      pres[B_LOW_VCC]                     = 1'b0;
      pres[B_THREE_VOLT]                  = three_q;
      pres[B_FIVE_VOLT]                   = ~five_off_q;
      pres[B_CARD_HI:B_CARD_LO]           = card_vcc_q;
      pres[B_BAD_REQ]                     = bad_q;
      pres[B_LOSS]                        = loss_q;
      pres[B_UNREC]                       = unrec_q;
      pres[B_READY_PIN]                   = sync_q[3];
      pres[B_WIDE_CARD]                   = wide_q;
      pres[B_NARROW_CARD]                 = narrow_q;
      pres[B_POWERED]                     = pwr_q;
      pres[B_DET_B]                       = det_q[1];
      pres[B_DET_A]                       = det_q[0];
      pres[B_STS_PIN]                     = sync_q[2];
   end

   // Next state of status, event and APB logic.
   always_comb
   begin
      det_d      = IDENT_ACTIVE ? det_q : sync_q[1:0];
      pwr_d      = SOCKET_POWERED;
      card_vcc_d = card_vcc_q;
      wide_d     = wide_q;
      narrow_d   = narrow_q;
      unrec_d    = unrec_q;
      bad_d      = bad_q;
      loss_d     = loss_q;
      three_d    = three_q;
      five_off_d = five_off_q;
      mask_d     = mask_q;
      reint_d    = 1'b0;
      if (wr_force)
      begin
         card_vcc_d = PWDATA[B_CARD_HI:B_CARD_LO];
         bad_d      = PWDATA[B_BAD_REQ];
         loss_d     = PWDATA[B_LOSS];
         unrec_d    = PWDATA[B_UNREC];
         wide_d     = PWDATA[B_WIDE_CARD];
         narrow_d   = PWDATA[B_NARROW_CARD];
         three_d    = PWDATA[B_THREE_VOLT];
         reint_d    = PWDATA[B_VS_TEST];
      end
      // An insertion in the same cycle wins over a force write, since it reports the real card.
      if (INSERT_DONE)
      begin
         card_vcc_d = CARD_VCC;
         wide_d     = CARD_WIDE;
         narrow_d   = CARD_NARROW;
         unrec_d    = CARD_INVALID;
      end
      // Hardware events win over a clearing force write.
      if (BAD_SUPPLY_REQ)
         bad_d = 1'b1;
      if (LOSS_EVENT)
         loss_d = 1'b1;
      if (done & PWRITE & hit(PADDR, OFF_CTRL))
         five_off_d = PWDATA[B_FIVE_OFF];
      if (done & PWRITE & hit(PADDR, OFF_MASK))
         mask_d = PWDATA[EV_W-1:0];
      ev_set = {pwr_d != pwr_q, det_d[1] != det_q[1], det_d[0] != det_q[0], sync_q[2] != sts_prev_q};
      if (wr_force)
         ev_set = ev_set | PWDATA[EV_W-1:0];
      // A read clears only the bits it returned, so a new event survives.
      ev_d = ev_q;
      if (done & ~PWRITE & hit(PADDR, OFF_EVENT))
         ev_d = ev_q & ~prdata_q[EV_W-1:0];
      ev_d     = ev_d | ev_set;
      irq_d    = |(ev_q & mask_q);
      pready_d = PSEL & PENABLE & ~pready_q;
      pslverr_d = PSEL & PENABLE & ~pready_q & ~mapped;
      prdata_d = prdata_q;
      if (PSEL & PENABLE & ~pready_q)
      begin
         prdata_d = RST_WORD;
         if (~PWRITE & hit(PADDR, OFF_EVENT))
            prdata_d[EV_W-1:0] = ev_q;
         if (~PWRITE & hit(PADDR, OFF_MASK))
            prdata_d[EV_W-1:0] = mask_q;
         if (~PWRITE & hit(PADDR, OFF_PRESENT))
            prdata_d = pres;
         if (~PWRITE & hit(PADDR, OFF_CTRL))
            prdata_d[B_FIVE_OFF] = five_off_q;
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         sts_prev_q <= 1'b0;
         det_q      <= RST_DETECT;
         pwr_q      <= 1'b0;
         card_vcc_q <= RST_CARD_VCC;
         wide_q     <= 1'b0;
         narrow_q   <= 1'b0;
         unrec_q    <= 1'b0;
         bad_q      <= 1'b0;
         loss_q     <= 1'b0;
         three_q    <= RST_THREE_CAP;
         five_off_q <= 1'b0;
         ev_q       <= RST_EVENT;
         mask_q     <= RST_MASK;
         pready_q   <= 1'b0;
         prdata_q   <= RST_WORD;
         pslverr_q  <= 1'b0;
         reint_q    <= 1'b0;
         irq_q      <= 1'b0;
      end
      else
      begin
         sts_prev_q <= sync_q[2];
         det_q      <= det_d;
         pwr_q      <= pwr_d;
         card_vcc_q <= card_vcc_d;
         wide_q     <= wide_d;
         narrow_q   <= narrow_d;
         unrec_q    <= unrec_d;
         bad_q      <= bad_d;
         loss_q     <= loss_d;
         three_q    <= three_d;
         five_off_q <= five_off_d;
         ev_q       <= ev_d;
         mask_q     <= mask_d;
         pready_q   <= pready_d;
         prdata_q   <= prdata_d;
         pslverr_q  <= pslverr_d;
         reint_q    <= reint_d;
         irq_q      <= irq_d;
      end
   end

   assign PRDATA        = prdata_q;
   assign PREADY        = pready_q;
   assign PSLVERR       = pslverr_q;
   assign REINTERROGATE = reint_q;
   assign IRQ           = irq_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   chk_low_caps_zero: assert property (pres[B_LOWEST_VCC:B_LOW_VCC] == 2'b00)
      else $error("low supply capability bits not zero");
   chk_three_volt_force: assert property (wr_force |=> pres[B_THREE_VOLT] == $past(PWDATA[B_THREE_VOLT]))
      else $error("three-volt capability does not follow force write");
   chk_five_volt_ctrl: assert property (done && PWRITE && hit(PADDR, OFF_CTRL)
      |=> pres[B_FIVE_VOLT] == !$past(PWDATA[B_FIVE_OFF]))
      else $error("five-volt capability does not follow control bit");
   chk_reserved_zero: assert property (pres[B_RSVD_HI:B_RSVD_LO] == 14'h0000)
      else $error("reserved bits not zero");
   chk_card_bits_hold: assert property (!INSERT_DONE && !wr_force
      |=> $stable(card_vcc_q) && $stable(wide_q) && $stable(narrow_q))
      else $error("card bits changed outside insertion");
   chk_card_insert: assert property (INSERT_DONE && !wr_force
      |=> card_vcc_q == $past(CARD_VCC) && wide_q == $past(CARD_WIDE))
      else $error("card bits not loaded at insertion");
   chk_detect_freeze: assert property (IDENT_ACTIVE |=> $stable(det_q))
      else $error("detect bits moved during identification");
   chk_bad_req_set: assert property (BAD_SUPPLY_REQ |=> pres[B_BAD_REQ])
      else $error("invalid supply request not flagged");
   chk_loss_set: assert property (LOSS_EVENT |=> pres[B_LOSS])
      else $error("data loss not flagged");
   chk_unrec_hold: assert property (!INSERT_DONE && !wr_force |=> $stable(unrec_q))
      else $error("unrecognised card flag changed");
   chk_ready_live: assert property (##2 1'b1 |-> pres[B_READY_PIN] == $past(CARD_READY_INTERRUPT_PIN, 2))
      else $error("ready pin level not reported");
   chk_detect_event: assert property ($changed(det_q) |-> ev_q[B_DET_B:B_DET_A] != 2'b00)
      else $error("detect change set no event");
   chk_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("APB answer not one wait state");

   // Live levels, power, insertion and force behaviour of the reported bits, event setting, interrupt, presence read and unmapped error.
   chk_powered_follow: assert property (##1 1'b1
      |-> pres[B_POWERED] == $past(SOCKET_POWERED))
      else $error("powered bit does not follow socket power");
   chk_detect_follow: assert property (!$past(IDENT_ACTIVE)
      |-> det_q == $past(sync_q[1:0]))
      else $error("detect bits do not follow detect pins");
   chk_status_live: assert property (##2 1'b1 |-> pres[B_STS_PIN] == $past(CARD_STATUS_CHANGE_PIN, 2))
      else $error("status-change pin level not reported");
   chk_narrow_insert: assert property (INSERT_DONE
      |=> narrow_q == $past(CARD_NARROW) && card_vcc_q == $past(CARD_VCC))
      else $error("narrow card flag not loaded at insertion");
   chk_unrec_insert: assert property (INSERT_DONE
      |=> unrec_q == $past(CARD_INVALID))
      else $error("unrecognised card flag not loaded at insertion");
   chk_force_card: assert property (wr_force && !INSERT_DONE
      |=> card_vcc_q == $past(PWDATA[B_CARD_HI:B_CARD_LO]) && wide_q == $past(PWDATA[B_WIDE_CARD]))
      else $error("force write not reflected in card bits");
   chk_reint_pulse: assert property (wr_force && PWDATA[B_VS_TEST] |=> REINTERROGATE)
      else $error("reinterrogation not requested");
   chk_power_event: assert property ($changed(pwr_q) |-> ev_q[EV_W-1])
      else $error("power change set no event");
   chk_status_event: assert property ($changed(sts_prev_q) |-> ev_q[0])
      else $error("status-change edge set no event");
   chk_irq_follow: assert property (##1 1'b1 |-> IRQ == $past(|(ev_q & mask_q)))
      else $error("interrupt does not follow masked events");
   chk_present_read: assert property (PSEL && PENABLE && !PREADY && !PWRITE && hit(PADDR, OFF_PRESENT)
      |=> PRDATA == $past(pres))
      else $error("presence read returned wrong word");
   chk_unmapped_err: assert property (PSEL && PENABLE && !PREADY && !mapped
      |=> PSLVERR && PRDATA == 32'h0000_0000)
      else $error("unmapped access not refused");

   cov_insert: cover property (INSERT_DONE ##1 done && !PWRITE && hit(PADDR, OFF_PRESENT));
   cov_irq: cover property ($rose(IRQ));
   cov_force: cover property (wr_force ##1 $changed(card_vcc_q));
   cov_freeze: cover property (IDENT_ACTIVE && sync_q[1:0] != det_q);
   cov_wide_card: cover property (INSERT_DONE && CARD_WIDE ##1 wide_q);
endmodule // ssp_top

// file: testbench.sv
/*
 Self-checking bench for the socket presence register bank over APB.
 Assumes the card model on the pins and one wait state per access.
*/
`timescale 1ns/100ps
module testbench;
   import ssp_pkg::*;
   logic        clk, rst_b, psel, penable, pwrite, ident, ins, wide, narrow;
   logic        invalid, bad, loss, pwr, present, sts, rdy, da, db, sp, rp;
   logic        pready, pslverr, reint, irq, seen, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  vcc;
   int          n_errors, tests_run;

   ssp_card card_u (.present(present), .sts_lvl(sts), .rdy_lvl(rdy),
      .det_a(da), .det_b(db), .sts_pin(sp), .rdy_pin(rp));
   ssp_top dut_u (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DETECT_PIN_A(da), .DETECT_PIN_B(db),
      .CARD_STATUS_CHANGE_PIN(sp), .CARD_READY_INTERRUPT_PIN(rp),
      .IDENT_ACTIVE(ident), .INSERT_DONE(ins), .CARD_VCC(vcc), .CARD_WIDE(wide),
      .CARD_NARROW(narrow), .CARD_INVALID(invalid), .BAD_SUPPLY_REQ(bad),
      .LOSS_EVENT(loss), .SOCKET_POWERED(pwr), .REINTERROGATE(reint), .IRQ(irq));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk or negedge rst_b)
      if (!rst_b)
         seen <= 1'b0;
      else if (reint === 1'b1)
         seen <= 1'b1;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; the request holds until PREADY is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         n_errors++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rreg(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   task automatic insert(input logic [3:0] v, input logic w, input logic n, input logic i);
      @(posedge clk);
      vcc     <= v;
      wide    <= w;
      narrow  <= n;
      invalid <= i;
      ins     <= 1'b1;
      @(posedge clk);
      ins <= 1'b0;
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (3000) @(posedge clk);
      n_errors++;
      summarize();
   end

   initial
   begin
      {psel, penable, pwrite, ident, ins, wide, narrow, invalid} = '0;
      {bad, loss, pwr, present, sts, rdy, rst_b} = '0;
      {paddr, pwdata, vcc} = '0;
      n_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(OFF_PRESENT, 32'h3000_0006, "presence");
      chk("slverr", 32'h0000_0000, {31'h0, er});
      rreg(OFF_EVENT, 32'h0000_0000, "event");
      rreg(OFF_CTRL, 32'h0000_0000, "control");
      present <= 1'b1;
      sts     <= 1'b1;
      rdy     <= 1'b1;
      repeat (5) @(posedge clk);
      rreg(OFF_PRESENT, 32'h3000_0041, "presence");
      rreg(OFF_EVENT, 32'h0000_0007, "event");
      ident   <= 1'b1;
      present <= 1'b0;
      repeat (5) @(posedge clk);
      rreg(OFF_PRESENT, 32'h3000_0000, "presence");
      present <= 1'b1;
      repeat (5) @(posedge clk);
      ident <= 1'b0;
      repeat (3) @(posedge clk);
      rreg(OFF_EVENT, 32'h0000_0001, "event");
      insert(4'hA, 1'b1, 1'b0, 1'b0);
      rreg(OFF_PRESENT, 32'h3000_2861, "presence");
      vcc  <= 4'h5;
      wide <= 1'b0;
      repeat (3) @(posedge clk);
      rreg(OFF_PRESENT, 32'h3000_2861, "presence");
      insert(4'h5, 1'b0, 1'b1, 1'b1);
      rreg(OFF_PRESENT, 32'h3000_14D1, "presence");
      insert(4'h5, 1'b0, 1'b1, 1'b0);
      bad  <= 1'b1;
      loss <= 1'b1;
      @(posedge clk);
      bad  <= 1'b0;
      loss <= 1'b0;
      apb(1'b1, OFF_MASK, 32'h0000_0008);
      rreg(OFF_MASK, 32'h0000_0008, "mask");
      pwr <= 1'b1;
      repeat (4) @(posedge clk);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      rreg(OFF_PRESENT, 32'h3000_1759, "presence");
      rreg(OFF_EVENT, 32'h0000_0008, "event");
      repeat (3) @(posedge clk);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, OFF_PRESENT, 32'h0000_0000);
      rreg(OFF_PRESENT, 32'h3000_1759, "presence");
      apb(1'b1, OFF_FORCE, 32'h0000_0C00);
      rreg(OFF_PRESENT, 32'h1000_0C49, "presence");
      apb(1'b1, OFF_FORCE, 32'h2000_4C01);
      rreg(OFF_PRESENT, 32'h3000_0C49, "presence");
      rreg(OFF_EVENT, 32'h0000_0001, "event");
      chk("reinterrogate", 32'h0000_0001, {31'h0, seen});
      rreg(OFF_FORCE, 32'h0000_0000, "force");
      apb(1'b1, OFF_CTRL, 32'h0000_0040);
      rreg(OFF_CTRL, 32'h0000_0040, "control");
      rreg(OFF_PRESENT, 32'h2000_0C49, "presence");
      rreg(12'h020, 32'h0000_0000, "unmapped");
      chk("slverr", 32'h0000_0001, {31'h0, er});
      summarize();
   end
endmodule // testbench
